// File: apc_clkgen.sv
// Master mode bit and frame clock generator from master clock edges
`timescale 1ns/1ps
module apc_clkgen (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Control
   input  wire logic       run,
   input  wire logic       src_edge,
   input  wire logic       div_sel,
   input  wire logic [3:0] rate_code,
   // Generated clocks
   output logic            bclk,
   output logic            fclk,
   output logic            bclk_fall,
   output logic            fclk_edge
);
   import apc_pkg::*;

   logic                   half_r;      // Prescale phase
   logic [ACC_W-1:0]       acc_r;       // Fractional frame phase
   logic                   bclk_r;      // Bit clock level
   logic                   fclk_r;      // Frame clock level
   logic                   bfall_r;     // Bit clock fall pulse
   logic                   fedge_r;     // Frame clock edge pulse
   wire                    src_tick;    // Effective source edge
   wire  [ACC_W-1:0]       num;         // Half frame in edges
   wire  [ACC_W-1:0]       den;         // Edge weight
   wire  [ACC_W:0]         acc_sum;     // Phase plus one edge
   wire                    wrap;        // Half frame reached

   // Direct or divided master clock
   assign src_tick = src_edge && (!div_sel || half_r);
   assign num      = rate_num(rate_code);
   assign den      = rate_den(rate_code);
   assign acc_sum  = {1'b0, acc_r} + {1'b0, den};
   assign wrap     = acc_sum >= {1'b0, num};

   assign bclk      = bclk_r;
   assign fclk      = fclk_r;
   assign bclk_fall = bfall_r;
   assign fclk_edge = fedge_r;

   // Prescale phase toggles on every master clock edge
   always_ff @(posedge clock) begin
      if (!rst_n || !run) begin
         half_r <= 1'b0;
      end else if (src_edge) begin
         half_r <= !half_r;
      end
   end

   // Bit clock follows source, frame clock by fractional count
   always_ff @(posedge clock) begin
      if (!rst_n || !run) begin
         acc_r   <= '0;
         bclk_r  <= 1'b0;
         fclk_r  <= 1'b0;
         bfall_r <= 1'b0;
         fedge_r <= 1'b0;
      end else begin
         bfall_r <= src_tick && bclk_r;
         fedge_r <= src_tick && wrap;
         if (src_tick) begin
            bclk_r <= !bclk_r;
            // Frame clock toggles each half frame
            if (wrap) begin
               acc_r  <= ACC_W'(acc_sum - {1'b0, num});
               fclk_r <= !fclk_r;
            end else begin
               acc_r  <= acc_sum[ACC_W-1:0];
            end
         end
      end
   end

endmodule

// File: apc_host.sv
// Far side model: master clock source and slave mode timing master
`timescale 1ns/1ps
module apc_host (
   input  wire logic drive,
   output logic      mclk_pin,
   output logic      bclk,
   output logic      fclk
);
   int n = 0;  // Bit clock edges in this half frame
   initial {mclk_pin, bclk, fclk} = 3'h0;
   // Free running 6 MHz master clock
   always #83.333 mclk_pin = ~mclk_pin;
   // Clocks only while the device leaves its bit clock pin undriven (slave or Hi-Z)
   always @(posedge mclk_pin) begin
      if (drive) begin
         bclk <= ~bclk;
         n <= (n == 31) ? 0 : n + 1;
         if (n == 31) fclk <= ~fclk;
      end
   end
endmodule

// File: apc_monitor.sv
// Checker for pin drive enables and bus timing of the audio port
`timescale 1ns/1ps
module apc_monitor (
   // Clock, reset and bus
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   // Pin enables
   input wire logic        port_bit_clock_oe,
   input wire logic        port_frame_clock_oe,
   input wire logic [1:0]  port_serial_out,
   input wire logic [1:0]  port_serial_out_oe
);
   logic [6:0] c_r;  // Shadow of control bits
   logic       s_r;  // Some slot enabled
   wire        wr = avs_write && !avs_waitrequest;  // Accepted write
   // Follow accepted control and slot writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         c_r <= 7'h47;
         s_r <= 1'b0;
      end else if (wr && avs_address == 5'h00) begin
         c_r[3:0] <= avs_writedata[3:0];
         c_r[6:5] <= avs_writedata[6:5];
         if (c_r[5] || c_r[6]) c_r[4] <= avs_writedata[4];
      end else if (wr && avs_address == 5'h08) begin
         s_r <= |avs_writedata[7:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_path_one_float: assert property (
      c_r[0] |=> !port_serial_out_oe[0]) else $error("out1 driven");
   a_float_data_low: assert property (
      (port_serial_out & ~port_serial_out_oe) == 2'h0)
      else $error("data on floated pin");
   a_multislot_out2_float: assert property (
      !c_r[2] |=> !port_serial_out_oe[1]) else $error("out2 driven");
   a_no_slot_float: assert property (
      !c_r[2] && !s_r |=> !port_serial_out_oe[0]) else $error("out1 on");
   a_hiz_outputs_float: assert property (
      c_r[3] |=> port_serial_out_oe == 2'h0) else $error("hiz outputs");
   a_hiz_clocks_float: assert property (
      c_r[3] |=> !port_bit_clock_oe && !port_frame_clock_oe)
      else $error("hiz clocks");
   a_slave_clock_inputs: assert property (
      !c_r[4] |=> !port_bit_clock_oe && !port_frame_clock_oe)
      else $error("slave drives");
   a_master_clock_drive: assert property (
      c_r[4] && !c_r[3] |=> port_bit_clock_oe && port_frame_clock_oe)
      else $error("master idle");
   a_bus_one_wait: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("late answer");
   a_wait_low_pulse: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("wait stuck low");
   cover property (port_bit_clock_oe);
   cover property (c_r[3] && c_r[4]);
   cover property (!c_r[2] && !s_r && c_r[4]);
endmodule
bind apc_top apc_monitor u_mon (.clock, .rst_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_waitrequest, .port_bit_clock_oe,
   .port_frame_clock_oe, .port_serial_out_oe, .port_serial_out);

// File: apc_pkg.sv
// Package holding the audio port control constants, types and decoders
package apc_pkg;

   // Bus geometry
   localparam int ADDR_W   = 5;              // Byte address width
   localparam int DATA_W   = 32;             // Data bus width
   localparam int BE_W     = 4;              // Byte enable width

   // Register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00;  // Port control
   localparam logic [4:0] OFS_RATE = 5'h04;  // Sample rate code
   localparam logic [4:0] OFS_SLOT = 5'h08;  // Slot transmit enables
   localparam logic [4:0] OFS_STAT = 5'h0C;  // Port status
   localparam logic [4:0] OFS_TXD0 = 5'h10;  // Channel 0 word
   localparam logic [4:0] OFS_TXD1 = 5'h14;  // Channel 1 word
   localparam logic [4:0] OFS_TXD2 = 5'h18;  // Channel 2 word
   localparam logic [4:0] OFS_TXD3 = 5'h1C;  // Channel 3 word

   // Control field positions
   localparam int CB_PDN1   = 0;   // out_path_powerdown, output 1
   localparam int CB_PDN2   = 1;   // out_path_powerdown, output 2
   localparam int CB_MSPDN  = 2;   // multislot_powerdown
   localparam int CB_HIZ    = 3;   // port_hiz_ctrl
   localparam int CB_MSEL   = 4;   // port_master_select
   localparam int CB_ULP    = 5;   // ultralow_power_down
   localparam int CB_LP     = 6;   // low_power_down
   localparam int CB_DIV    = 7;   // Master clock prescale by two
   localparam int CB_RATIO  = 8;   // internal_ratio_select scaling
   localparam int CTRL_W    = 9;   // Control register width

   // Status field positions
   localparam int SB_BOE    = 0;   // Bit clock pin driven
   localparam int SB_FOE    = 1;   // Frame clock pin driven
   localparam int SB_SOE1   = 2;   // Serial output 1 driven
   localparam int SB_SOE2   = 3;   // Serial output 2 driven
   localparam int SB_TDM    = 4;   // Multislot mode active
   localparam int SB_MST    = 5;   // Timing master
   localparam int SB_IDIV   = 6;   // Internal divider, two bits
   localparam int SB_FLVL   = 8;   // Frame clock level
   localparam int SB_RUN    = 9;   // Clock generator running

   // Reset values
   localparam logic [8:0] CTRL_RST = 9'h047;  // Paths and port down
   localparam logic [3:0] RATE_RST = 4'h1;    // 8 kHz
   localparam logic [7:0] SLOT_RST = 8'h00;   // No slots

   // Frame geometry
   localparam int WORD_W    = 16;  // Bits per channel word
   localparam int NUM_CH    = 4;   // Channel words
   localparam int NUM_SLOT  = 8;   // Multislot slots per frame
   localparam int CNT_W     = 8;   // Bit counter width
   localparam int ACC_W     = 17;  // Frame accumulator width

   // Sample rate codes
   localparam logic [3:0] RATE_8K    = 4'h1;
   localparam logic [3:0] RATE_11K   = 4'h2;
   localparam logic [3:0] RATE_11K29 = 4'h3;
   localparam logic [3:0] RATE_12K   = 4'h4;
   localparam logic [3:0] RATE_16K   = 4'h5;
   localparam logic [3:0] RATE_22K   = 4'h6;
   localparam logic [3:0] RATE_22K59 = 4'h7;
   localparam logic [3:0] RATE_24K   = 4'h8;
   localparam logic [3:0] RATE_32K   = 4'h9;
   localparam logic [3:0] RATE_44K   = 4'hA;

   // Internal rate divider
   typedef enum logic [1:0] {
      IDIV_1 = 2'b00,
      IDIV_2 = 2'b01,
      IDIV_4 = 2'b10
   } apc_idiv_t;

   // Bus slave states
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } apc_bus_t;

   // Known rate codes
   function automatic logic rate_valid(input logic [3:0] c);
      rate_valid = (c >= RATE_8K) && (c <= RATE_44K);
   endfunction

   // Frame period numerator, in master clock cycles
   function automatic logic [16:0] rate_num(input logic [3:0] c);
      case (c)
         RATE_11K:   rate_num = 17'h13880;  // 80000/147
         RATE_11K29: rate_num = 17'h00220;  // 544
         RATE_12K:   rate_num = 17'h001F4;  // 500
         RATE_16K:   rate_num = 17'h00177;  // 375
         RATE_22K:   rate_num = 17'h09C40;  // 40000/147
         RATE_22K59: rate_num = 17'h00110;  // 272
         RATE_24K:   rate_num = 17'h000FA;  // 250
         RATE_32K:   rate_num = 17'h00177;  // 375/2
         RATE_44K:   rate_num = 17'h04E20;  // 20000/147
         default:    rate_num = 17'h002EE;  // 750
      endcase
   endfunction

   // Frame period denominator
   function automatic logic [16:0] rate_den(input logic [3:0] c);
      case (c)
         RATE_11K, RATE_22K, RATE_44K: rate_den = 17'h00093;  // 147
         RATE_32K:                     rate_den = 17'h00002;
         default:                      rate_den = 17'h00001;
      endcase
   endfunction

endpackage

// File: apc_top.sv
// Audio port power, tristate, timing role and sample rate control
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Path powerdown floats its output, clocks untouched
// - Multislot powerdown one: stereo; zero: multislot
// - Multislot with no slots floats output one
// - Role follows master select only
// - Slave: clock pins always inputs
// - Hi-Z floats outputs; master also clocks
// - Master drives clock pins; slave reads them
// - Master clocks from divided or direct clock
// - Decode rate codes one through ten
// - Internal rate 48k, scaled by four for codes 1, 2, 4, by two for 5, 6, 8
// - Frame period from rate, 6 MHz clock
// - Frame clock marks frames or channels
module apc_top (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // Avalon-MM slave
   input  wire logic [apc_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [apc_pkg::BE_W-1:0]   avs_byteenable,
   input  wire logic [apc_pkg::DATA_W-1:0] avs_writedata,
   output logic      [apc_pkg::DATA_W-1:0] avs_readdata,
   output logic                            avs_waitrequest,
   // Master clock pin
   input  wire logic                       mclk_pin,
   // Bit clock pin
   input  wire logic                       port_bit_clock_in,
   output logic                            port_bit_clock_out,
   output logic                            port_bit_clock_oe,
   // Frame clock pin
   input  wire logic                       port_frame_clock_in,
   output logic                            port_frame_clock_out,
   output logic                            port_frame_clock_oe,
   // Serial output pins
   output logic      [1:0]                 port_serial_out,
   output logic      [1:0]                 port_serial_out_oe
);
   import apc_pkg::*;

   // Register state
   logic [CTRL_W-1:0]      ctrl_r;          // Control bits
   logic [3:0]             rate_r;          // sample_rate_code
   logic [NUM_SLOT-1:0]    slot_r;          // slot_tx_enable
   logic [WORD_W-1:0]      txd_r [NUM_CH];  // Channel words
   apc_bus_t               bus_r;           // Bus slave state
   logic                   wait_r;          // Waitrequest flop
   logic [DATA_W-1:0]      rdata_r;         // Read data flop

   // Pin synchronisers
   logic [2:0]             mclk_s;          // Master clock stages
   logic [2:0]             bin_s;           // Bit clock stages
   logic [2:0]             fin_s;           // Frame clock stages

   // Serial shifter
   logic [CNT_W-1:0]       bcnt_r;          // Bits since frame start
   logic [WORD_W-1:0]      sh1_r;           // Output 1 shift word
   logic [WORD_W-1:0]      sh2_r;           // Output 2 shift word

   // Pin flops
   logic                   bclk_o_r;        // Bit clock out
   logic                   bclk_oe_r;       // Bit clock enable
   logic                   fclk_o_r;        // Frame clock out
   logic                   fclk_oe_r;       // Frame clock enable
   logic [1:0]             sdo_r;           // Serial data out
   logic [1:0]             sdo_oe_r;        // Serial data enables

   // Decoded controls
   wire                    pdn1;            // Path 1 down
   wire                    pdn2;            // Path 2 down
   wire                    stereo;          // Two-channel mode
   wire                    hiz;             // Port Hi-Z
   wire                    master;          // Timing master
   wire                    powered_dn;      // Clock change allowed
   wire                    gen_run;         // Generator enable
   apc_idiv_t              idiv;            // Internal rate divider

   // Generator outputs
   wire                    gen_bclk;
   wire                    gen_fclk;
   wire                    gen_bfall;
   wire                    gen_fedge;

   // Selected timing
   wire                    mclk_edge;       // Master clock edge
   wire                    bit_fall;        // Shift event
   wire                    frame_edge;      // Frame clock edge
   wire                    frame_lvl;       // Frame clock level
   wire                    frame_start;     // Load event
   wire [2:0]              slot_idx;        // Current slot
   wire                    slot_on;         // Current slot enabled
   wire                    any_slot;        // Any slot enabled
   wire                    word_end;        // Last bit of slot

   // Output enable terms
   wire                    clk_oe;
   wire                    oe1;
   wire                    oe2;

   // Bus decode
   wire                    req;
   wire                    wr_go;
   wire                    hit_ctrl;
   wire                    hit_rate;
   wire                    hit_slot;
   wire                    hit_stat;
   wire                    hit_txd;
   wire [1:0]              txd_sel;
   wire [DATA_W-1:0]       stat_word;
   wire [DATA_W-1:0]       rd_mux;
   wire [3:0]              new_rate;
   wire [CTRL_W-1:0]       ctrl_wr;
   wire [CTRL_W-1:0]       ctrl_nxt;

   // Merge a 16-bit register with byte enabled write data
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8],
                 be[0] ? wd[7:0]  : old[7:0]};
   endfunction

   // Control field decode
   assign pdn1       = ctrl_r[CB_PDN1];
   assign pdn2       = ctrl_r[CB_PDN2];
   assign stereo     = ctrl_r[CB_MSPDN];
   assign hiz        = ctrl_r[CB_HIZ];
   assign master     = ctrl_r[CB_MSEL];
   assign powered_dn = ctrl_r[CB_ULP] || ctrl_r[CB_LP];
   // Generator halts while the clock settings may change
   assign gen_run    = master && !powered_dn;

   // Internal rate: 48k unscaled; with ratio select, 8k/11k/12k by four, 16k/22k/24k by two, other codes unscaled
   assign idiv = !ctrl_r[CB_RATIO] ? IDIV_1 :
                 (rate_r == RATE_8K  || rate_r == RATE_11K ||
                  rate_r == RATE_12K) ? IDIV_4 :
                 (rate_r == RATE_16K || rate_r == RATE_22K ||
                  rate_r == RATE_24K) ? IDIV_2 :
                 IDIV_1;

   // Bus request decode
   assign req      = avs_read || avs_write;
   assign wr_go    = (bus_r == BUS_ACK) && avs_write;
   assign hit_ctrl = avs_address == OFS_CTRL;
   assign hit_rate = avs_address == OFS_RATE;
   assign hit_slot = avs_address == OFS_SLOT;
   assign hit_stat = avs_address == OFS_STAT;
   assign hit_txd  = avs_address[4] && (avs_address[1:0] == 2'b00);
   assign txd_sel  = avs_address[3:2];

   // Status word shows the block's live state
   assign stat_word = {22'h000000,
                       gen_run,
                       frame_lvl,
                       idiv,
                       master,
                       !stereo,
                       sdo_oe_r[1],
                       sdo_oe_r[0],
                       fclk_oe_r,
                       bclk_oe_r};

   // Read selection, unmapped reads return zero
   assign rd_mux = hit_ctrl ? {23'h000000, ctrl_r} :
                   hit_rate ? {28'h0000000, rate_r} :
                   hit_slot ? {24'h000000, slot_r} :
                   hit_stat ? stat_word :
                   hit_txd  ? {16'h0000, txd_r[txd_sel]} :
                   32'h00000000;

   // Rate write: reserved codes or running clocks keep old code
   assign new_rate = (rate_valid(avs_writedata[3:0]) && powered_dn &&
                      avs_byteenable[0]) ?
                     avs_writedata[3:0] : rate_r;

   // Control write, clock fields only while powered down
   assign ctrl_wr = {avs_byteenable[1] ? avs_writedata[8] : ctrl_r[8],
                     avs_byteenable[0] ? avs_writedata[7:0]
                                       : ctrl_r[7:0]};
   assign ctrl_nxt = {powered_dn ? ctrl_wr[CB_RATIO] : ctrl_r[CB_RATIO],
                      powered_dn ? ctrl_wr[CB_DIV]   : ctrl_r[CB_DIV],
                      ctrl_wr[CB_LP:CB_ULP],
                      powered_dn ? ctrl_wr[CB_MSEL]  : ctrl_r[CB_MSEL],
                      ctrl_wr[CB_HIZ:CB_PDN1]};

   // Avalon handshake: one wait cycle then one ready cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bus_r   <= BUS_IDLE;
         wait_r  <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         case (bus_r)
            BUS_IDLE: begin
               // Capture read data, drop waitrequest
               if (req) begin
                  bus_r   <= BUS_ACK;
                  wait_r  <= 1'b0;
                  rdata_r <= avs_read ? rd_mux : 32'h00000000;
               end
            end
            BUS_ACK: begin
               // Transfer completes at this edge
               bus_r  <= BUS_IDLE;
               wait_r <= 1'b1;
            end
            default: begin
               bus_r  <= BUS_IDLE;
               wait_r <= 1'b1;
            end
         endcase
      end
   end

   // Register writes commit when waitrequest is sampled low
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         rate_r <= RATE_RST;
         slot_r <= SLOT_RST;
      end else if (wr_go) begin
         if (hit_ctrl) begin
            ctrl_r <= ctrl_nxt;
         end else if (hit_rate) begin
            rate_r <= new_rate;
         end else if (hit_slot && avs_byteenable[0]) begin
            slot_r <= avs_writedata[NUM_SLOT-1:0];
         end
      end
   end

   // Channel word registers
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_txd
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               txd_r[gi] <= 16'h0000;
            end else if (wr_go && hit_txd && txd_sel == 2'(gi)) begin
               txd_r[gi] <= merge16(txd_r[gi], avs_writedata[15:0],
                                    avs_byteenable[1:0]);
            end
         end
      end
   endgenerate

   // Two-flop synchronisers plus an edge stage for the pins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mclk_s <= 3'h0;
         bin_s  <= 3'h0;
         fin_s  <= 3'h0;
      end else begin
         mclk_s <= {mclk_s[1:0], mclk_pin};
         bin_s  <= {bin_s[1:0], port_bit_clock_in};
         fin_s  <= {fin_s[1:0], port_frame_clock_in};
      end
   end

   // Master clock edge of either polarity
   assign mclk_edge = mclk_s[1] ^ mclk_s[2];

   // Clock generator for master mode
   apc_clkgen u_clkgen (
      .clock     (clock),
      .rst_n     (rst_n),
      .run       (gen_run),
      .src_edge  (mclk_edge),
      .div_sel   (ctrl_r[CB_DIV]),
      .rate_code (rate_r),
      .bclk      (gen_bclk),
      .fclk      (gen_fclk),
      .bclk_fall (gen_bfall),
      .fclk_edge (gen_fedge)
   );

   // Timing source follows the role
   assign bit_fall   = master ? gen_bfall
                              : (bin_s[2] && !bin_s[1]);
   assign frame_edge = master ? gen_fedge
                              : (fin_s[1] ^ fin_s[2]);
   assign frame_lvl  = master ? gen_fclk : fin_s[1];
   // Multislot frames start on rising edge, stereo on both
   assign frame_start = frame_edge && (stereo || frame_lvl);

   // Slot tracking
   assign slot_idx = bcnt_r[6:4];
   assign slot_on  = !bcnt_r[7] && slot_r[slot_idx];
   assign any_slot = |slot_r;
   assign word_end = bcnt_r[3:0] == 4'hF;

   // Serial shifter, words load at frame or slot boundary
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bcnt_r <= '0;
         sh1_r  <= 16'h0000;
         sh2_r  <= 16'h0000;
      end else if (frame_start) begin
         bcnt_r <= '0;
         if (stereo) begin
            // Low frame clock is left, high is right
            sh1_r <= frame_lvl ? txd_r[1] : txd_r[0];
            sh2_r <= frame_lvl ? txd_r[3] : txd_r[2];
         end else begin
            sh1_r <= txd_r[0];
            sh2_r <= 16'h0000;
         end
      end else if (bit_fall) begin
         if (!bcnt_r[7]) begin
            bcnt_r <= CNT_W'(bcnt_r + 8'h01);
         end
         if (!stereo && word_end) begin
            // Next slot carries channel slot mod four
            sh1_r <= txd_r[2'(slot_idx + 3'h1)];
         end else begin
            sh1_r <= {sh1_r[WORD_W-2:0], 1'b0};
         end
         sh2_r <= {sh2_r[WORD_W-2:0], 1'b0};
      end
   end

   // Clock pins driven only as master and not in Hi-Z
   assign clk_oe = master && !hiz;
   // Output 1: path up, not Hi-Z, stereo or an active slot
   assign oe1 = !pdn1 && !hiz &&
                (stereo || (any_slot && slot_on));
   // Output 2 exists only in stereo mode
   assign oe2 = !pdn2 && !hiz && stereo;

   // Pin flops
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bclk_o_r  <= 1'b0;
         bclk_oe_r <= 1'b0;
         fclk_o_r  <= 1'b0;
         fclk_oe_r <= 1'b0;
         sdo_r     <= 2'h0;
         sdo_oe_r  <= 2'h0;
      end else begin
         bclk_o_r  <= gen_bclk;
         bclk_oe_r <= clk_oe;
         fclk_o_r  <= gen_fclk;
         fclk_oe_r <= clk_oe;
         sdo_r     <= {sh2_r[WORD_W-1] && oe2,
                       sh1_r[WORD_W-1] && oe1};
         sdo_oe_r  <= {oe2, oe1};
      end
   end

   // Outputs straight from flops
   assign avs_readdata         = rdata_r;
   assign avs_waitrequest      = wait_r;
   assign port_bit_clock_out   = bclk_o_r;
   assign port_bit_clock_oe    = bclk_oe_r;
   assign port_frame_clock_out = fclk_o_r;
   assign port_frame_clock_oe  = fclk_oe_r;
   assign port_serial_out      = sdo_r;
   assign port_serial_out_oe   = sdo_oe_r;

endmodule

// File: apc_top_test.sv
// Self-checking bench for the audio port control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module apc_top_test;
   import apc_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, e, m, r, w0, q_e[$], q_m[$];
   logic        avs_waitrequest, bo, boe, fo, foe, hb, hf, mclk;
   logic [1:0]  so, so_oe;
   int          n_fail = 0, samples_checked = 0, seed = 60;
   realtime     t0;
   always #2 clock = ~clock;
   apc_host u_host (.drive(!boe), .mclk_pin(mclk), .bclk(hb), .fclk(hf));
   apc_top DUT (.clock, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_byteenable(4'hF), .avs_writedata, .avs_readdata,
      .avs_waitrequest, .mclk_pin(mclk), .port_bit_clock_in(boe ? bo : hb),
      .port_bit_clock_out(bo), .port_bit_clock_oe(boe),
      .port_frame_clock_in(foe ? fo : hf), .port_frame_clock_out(fo),
      .port_frame_clock_oe(foe), .port_serial_out(so),
      .port_serial_out_oe(so_oe));
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, logic [4:0] a, logic [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clock); while (avs_waitrequest);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [4:0] a, logic [31:0] ex, mk);
      q_e.push_back(ex);
      q_m.push_back(mk);
      bus(1'b0, a, 32'h0);
   endtask
   // Compare each accepted read with the oldest note
   always @(posedge clock) begin
      if (avs_read && !avs_waitrequest && q_e.size() > 0) begin
         e = q_e.pop_front();
         m = q_m.pop_front();
         `CHK("readback", e, avs_readdata & m)
      end
   end
   task automatic print_verdict;
      `CHK("pending", 32'h0, 32'(q_e.size()))
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #300000;
      n_fail++;
      print_verdict;
   end
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(5'h00, 32'h47, 32'h1FF);
      for (int i = 1; i <= 11; i++) begin
         bus(1'b1, 5'h04, 32'(i));
         rd(5'h04, (i > 10) ? 32'hA : 32'(i), 32'hF);
      end
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         if (i == 0) w0 = r;
         bus(1'b1, 5'h10 + 5'(4 * i), r);
         rd(5'h10 + 5'(4 * i), {16'h0, r[15:0]}, 32'hFFFF);
      end
      bus(1'b1, 5'h04, 32'h8);
      bus(1'b1, 5'h00, 32'h157);
      rd(5'h0C, 32'h63, 32'hFF);
      bus(1'b1, 5'h00, 32'h17);
      bus(1'b1, 5'h04, 32'h5);
      rd(5'h04, 32'h8, 32'hF);
      rd(5'h0C, 32'h23, 32'hFF);
      @(posedge fo) t0 = $realtime;
      @(posedge fo);
      t0 = $realtime - t0;
      `CHK("frame", 1'b1, t0 > 41640 && t0 < 41690)
      bus(1'b1, 5'h00, 32'h14);
      rd(5'h0C, 32'h2F, 32'hFF);
      @(negedge fo);
      for (int b = 15; b >= 0; b--) begin
         @(posedge bo);
         `CHK("serial", w0[b], so[0])
      end
      bus(1'b1, 5'h00, 32'h10);
      rd(5'h0C, 32'h33, 32'hFF);
      bus(1'b1, 5'h08, $random(seed) | 32'h1);
      bus(1'b1, 5'h08, 32'h0);
      bus(1'b1, 5'h00, 32'h13);
      bus(1'b1, 5'h00, 32'h17);
      bus(1'b1, 5'h00, 32'h1F);
      rd(5'h0C, 32'h20, 32'hFF);
      bus(1'b1, 5'h00, 32'h17);
      bus(1'b1, 5'h00, 32'h57);
      bus(1'b1, 5'h00, 32'h47);
      bus(1'b1, 5'h00, 32'h0F);
      rd(5'h0C, 32'h00, 32'hFF);
      print_verdict;
   end
endmodule
